// >>> design/pifr_defs.svh
// register offsets, field positions and reset values for the interrupt flag/enable block
`ifndef PIFR_DEFS_SVH
`define PIFR_DEFS_SVH
`define PIFR_OFF_SERIAL     12'h000
`define PIFR_OFF_TIMER      12'h004
`define PIFR_OFF_PERIODIC   12'h008
`define PIFR_OFF_MEMLV      12'h00C
`define PIFR_OFF_STATUS     12'h010
`define PIFR_REG_RESET      8'h00
// serial control: flags 5:4, enables 1:0
`define PIFR_SER_SIM_FLAG   4
`define PIFR_SER_ASYNC_FLAG 5
`define PIFR_SER_SIM_EN     0
`define PIFR_SER_ASYNC_EN   1
// implemented-bit masks per configuration
`define PIFR_MASK_SER_SMALL 8'h11
`define PIFR_MASK_SER_ASYNC 8'h33
`define PIFR_MASK_HALF      8'h33
`define PIFR_MASK_FULL      8'hFF
// flag field is bits 7:4, enable field bits 3:0 in every control register; the status word at 0x010 is laid out differently
`define PIFR_FLAG_LSB       4
`define PIFR_FIELD_W        4
`endif

// >>> design/pifr_pkg.sv
// types for the interrupt flag/enable block
package pifr_pkg;
  typedef struct packed {
    logic serial_iface;
    logic async_port;
    logic compact_tmr_a;
    logic compact_tmr_p;
    logic standard_tmr_a;
    logic standard_tmr_p;
    logic periodic_tmr0_a;
    logic periodic_tmr0_p;
    logic periodic_tmr1_a;
    logic periodic_tmr1_p;
    logic eeprom;
    logic low_voltage;
  } pifr_events_t;

  typedef struct packed {
    logic [7:0] serial;
    logic [7:0] timer;
    logic [7:0] periodic;
    logic [7:0] memlv;
  } pifr_regs_t;
endpackage

// >>> design/pifr_ctl_reg.sv
// one 8-bit flag/enable control register with hardware set on flags
`timescale 1ns/1ps
`include "pifr_defs.svh"
module pifr_ctl_reg #(
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] hw_set,
  output logic      [7:0] value
);
  logic [7:0] value_reg;
  logic [7:0] value_next;

  always_comb begin
    value_next = value_reg;
    if (wr_en) begin
      value_next = wr_data & IMPL_MASK;
    end
    value_next = value_next | (hw_set & IMPL_MASK);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_reg <= `PIFR_REG_RESET;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;
endmodule // pifr_ctl_reg

// >>> design/pifr_irq_regs.sv
// apb-accessed interrupt request flag and enable registers for peripheral sources
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "pifr_defs.svh"

// Contract
// - unimplemented bits read zero and ignore writes
// - serial control bit 4 is serial-interface request flag
// - serial control bit 0 is serial-interface interrupt enable
// - with async port: its flag at bit 5, enable at bit 1
// - first multi-function register: compact timer A flag bit 5, enable bit 1
// - compact timer P flag bit 4, enable bit 0
// - standard timer A flag bit 7, enable bit 3
// - standard timer P flag bit 6, enable bit 2
// - single periodic timer: A flag bit 5, enable bit 1; 7,6,3,2 unused
// - single periodic timer: P flag bit 4, enable bit 0
// - dual periodic: timer1 A enable bit 3, flag bit 7
// - dual periodic: timer1 P flag bit 6, enable bit 2
// - dual periodic: timer0 A flag bit 5, enable bit 1
// - dual periodic: timer0 P flag bit 4, enable bit 0
// - third register: eeprom flag bit 5, enable bit 1
// - third register: low-voltage flag bit 4, enable bit 0; others unused
// - a set flag raises a request only when its enable is 1
// - global enable low blocks all requests; flags still set
// - any flag becoming set wakes the device; preset flags do not
module pifr_irq_regs #(
  parameter bit HAS_ASYNC_PORT    = 1'b1,
  parameter bit HAS_STANDARD_TMR  = 1'b1,
  parameter bit HAS_DUAL_PERIODIC = 1'b1
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire pifr_pkg::pifr_events_t events,
  input  wire logic                 global_irq_en,
  output pifr_pkg::pifr_events_t    irq_pending,
  output logic                      irq_request,
  output logic                      wake_up
);
  localparam logic [7:0] SER_MASK  = HAS_ASYNC_PORT ? `PIFR_MASK_SER_ASYNC
                                                    : `PIFR_MASK_SER_SMALL;
  localparam logic [7:0] TMR_MASK  = HAS_STANDARD_TMR ? `PIFR_MASK_FULL : `PIFR_MASK_HALF;
  localparam logic [7:0] PER_MASK  = HAS_DUAL_PERIODIC ? `PIFR_MASK_FULL : `PIFR_MASK_HALF;
  localparam logic [7:0] MEM_MASK  = `PIFR_MASK_HALF;

  pifr_pkg::pifr_regs_t regs;
  pifr_pkg::pifr_regs_t set_vec;
  logic [3:0]           wr_sel;
  logic                 wr_ok;
  logic                 addr_hit;
  logic [31:0]          prdata_reg;
  logic [31:0]          prdata_next;
  logic                 pslverr_reg;
  logic [15:0]          flags_now;
  logic [15:0]          flags_prev_reg;
  logic                 wake_reg;
  logic                 irq_reg;

  // event strobes mapped onto flag bit positions of each register
  always_comb begin
    set_vec = '0;
    set_vec.serial[`PIFR_SER_SIM_FLAG]   = events.serial_iface;
    set_vec.serial[`PIFR_SER_ASYNC_FLAG] = events.async_port;
    set_vec.timer[7]    = events.standard_tmr_a;
    set_vec.timer[6]    = events.standard_tmr_p;
    set_vec.timer[5]    = events.compact_tmr_a;
    set_vec.timer[4]    = events.compact_tmr_p;
    set_vec.periodic[7] = events.periodic_tmr1_a;
    set_vec.periodic[6] = events.periodic_tmr1_p;
    set_vec.periodic[5] = events.periodic_tmr0_a;
    set_vec.periodic[4] = events.periodic_tmr0_p;
    set_vec.memlv[5]    = events.eeprom;
    set_vec.memlv[4]    = events.low_voltage;
  end

  // apb: zero-wait slave, byte 0 lane carries the 8-bit register
  assign addr_hit = (paddr == `PIFR_OFF_SERIAL) || (paddr == `PIFR_OFF_TIMER) ||
                    (paddr == `PIFR_OFF_PERIODIC) || (paddr == `PIFR_OFF_MEMLV) ||
                    (paddr == `PIFR_OFF_STATUS);
  assign wr_ok = psel && penable && pwrite && pstrb[0];
  assign wr_sel[0] = wr_ok && (paddr == `PIFR_OFF_SERIAL);
  assign wr_sel[1] = wr_ok && (paddr == `PIFR_OFF_TIMER);
  assign wr_sel[2] = wr_ok && (paddr == `PIFR_OFF_PERIODIC);
  assign wr_sel[3] = wr_ok && (paddr == `PIFR_OFF_MEMLV);

  pifr_ctl_reg #(.IMPL_MASK(SER_MASK)) u_serial (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_sel[0]),
    .wr_data (pwdata[7:0]),
    .hw_set  (set_vec.serial),
    .value   (regs.serial)
  );

  pifr_ctl_reg #(.IMPL_MASK(TMR_MASK)) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_sel[1]),
    .wr_data (pwdata[7:0]),
    .hw_set  (set_vec.timer),
    .value   (regs.timer)
  );

  pifr_ctl_reg #(.IMPL_MASK(PER_MASK)) u_periodic (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_sel[2]),
    .wr_data (pwdata[7:0]),
    .hw_set  (set_vec.periodic),
    .value   (regs.periodic)
  );

  pifr_ctl_reg #(.IMPL_MASK(MEM_MASK)) u_memlv (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_sel[3]),
    .wr_data (pwdata[7:0]),
    .hw_set  (set_vec.memlv),
    .value   (regs.memlv)
  );

  // pending = flag and its enable, per bit pair
  logic [15:0] pend_bits;
  genvar gi;
  generate
    for (gi = 0; gi < `PIFR_FIELD_W; gi = gi + 1) begin : g_pend
      assign pend_bits[gi]      = regs.serial[gi + `PIFR_FLAG_LSB] & regs.serial[gi];
      assign pend_bits[gi + 4]  = regs.timer[gi + `PIFR_FLAG_LSB] & regs.timer[gi];
      assign pend_bits[gi + 8]  = regs.periodic[gi + `PIFR_FLAG_LSB] & regs.periodic[gi];
      assign pend_bits[gi + 12] = regs.memlv[gi + `PIFR_FLAG_LSB] & regs.memlv[gi];
      assign flags_now[gi]      = regs.serial[gi + `PIFR_FLAG_LSB];
      assign flags_now[gi + 4]  = regs.timer[gi + `PIFR_FLAG_LSB];
      assign flags_now[gi + 8]  = regs.periodic[gi + `PIFR_FLAG_LSB];
      assign flags_now[gi + 12] = regs.memlv[gi + `PIFR_FLAG_LSB];
    end
  endgenerate

  always_comb begin
    irq_pending                 = '0;
    irq_pending.serial_iface    = pend_bits[0];
    irq_pending.async_port      = pend_bits[1];
    irq_pending.compact_tmr_p   = pend_bits[4];
    irq_pending.compact_tmr_a   = pend_bits[5];
    irq_pending.standard_tmr_p  = pend_bits[6];
    irq_pending.standard_tmr_a  = pend_bits[7];
    irq_pending.periodic_tmr0_p = pend_bits[8];
    irq_pending.periodic_tmr0_a = pend_bits[9];
    irq_pending.periodic_tmr1_p = pend_bits[10];
    irq_pending.periodic_tmr1_a = pend_bits[11];
    irq_pending.low_voltage     = pend_bits[12];
    irq_pending.eeprom          = pend_bits[13];
  end

  // request to the vectoring logic gated by the global enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= global_irq_en && (|pend_bits);
    end
  end
  assign irq_request = irq_reg;

  // wake on a 0->1 flag transition; a flag already set gives no new edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_prev_reg <= 16'h0000;
      wake_reg       <= 1'b0;
    end else begin
      flags_prev_reg <= flags_now;
      wake_reg       <= |(flags_now & ~flags_prev_reg);
    end
  end
  assign wake_up = wake_reg;

  always_comb begin
    prdata_next = 32'h0000_0000;
    if (paddr == `PIFR_OFF_SERIAL) begin
      prdata_next[7:0] = regs.serial;
    end else if (paddr == `PIFR_OFF_TIMER) begin
      prdata_next[7:0] = regs.timer;
    end else if (paddr == `PIFR_OFF_PERIODIC) begin
      prdata_next[7:0] = regs.periodic;
    end else if (paddr == `PIFR_OFF_MEMLV) begin
      prdata_next[7:0] = regs.memlv;
    end else if (paddr == `PIFR_OFF_STATUS) begin
      prdata_next[15:0] = pend_bits;
      prdata_next[16]   = irq_reg;
    end
  end

  // read data registered in the setup cycle so it is stable in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : prdata_next;
      pslverr_reg <= !addr_hit;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = pslverr_reg && psel && penable;
endmodule // pifr_irq_regs

// >>> tb/pifr_irq_regs_sva.sv
// assertion checker for the interrupt flag/enable register block
`timescale 1ns/1ps
module pifr_irq_regs_sva (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire pifr_pkg::pifr_events_t events,
  input wire logic                   global_irq_en,
  input wire pifr_pkg::pifr_events_t irq_pending,
  input wire logic                   irq_request,
  input wire logic                   wake_up
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_rd;
    psel && penable && !pwrite;
  endsequence
  a_irq_follow: assert property (irq_request == $past(global_irq_en && |irq_pending))
    else $error("request not pending and enable");
  a_global_block: assert property (!global_irq_en |=> !irq_request)
    else $error("request while globally disabled");
  a_wake_cause: assert property (wake_up |->
    $past(|events, 2) || $past(psel && pwrite, 2))
    else $error("wake without event or write");
  a_pend_cause: assert property (|(irq_pending & ~$past(irq_pending))
    |-> $past(|events) || $past(psel && penable && pwrite))
    else $error("pending rose without cause");
  a_err_unmapped: assert property (s_acc ##0 (paddr > 12'h010) |-> pslverr)
    else $error("no error on unmapped access");
  a_rd_unmapped: assert property (s_rd ##0 (paddr > 12'h010) |-> prdata == 0)
    else $error("unmapped read not zero");
  a_unimpl_zero: assert property (s_rd ##0 (paddr == 12'h000 || paddr == 12'h00C)
    |-> (prdata & 32'hFFFF_FFCC) == 0)
    else $error("unimplemented bits not zero");
  a_upper_zero: assert property (s_rd ##0 (paddr < 12'h010) |-> prdata[31:8] == 0)
    else $error("upper read bits not zero");
endmodule // pifr_irq_regs_sva
bind pifr_irq_regs pifr_irq_regs_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .events, .global_irq_en, .irq_pending,
  .irq_request, .wake_up);

// >>> tb/pifr_evt_src.sv
// peripheral event source model: one-cycle strobes on request
`timescale 1ns/1ps
module pifr_evt_src (
  input  wire logic [11:0]        fire,
  input  wire logic               pclk,
  input  wire logic               presetn,
  output pifr_pkg::pifr_events_t  events
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events <= '0;
    end else begin
      events <= pifr_pkg::pifr_events_t'(fire);
    end
  end
endmodule // pifr_evt_src

// >>> tb/tb.sv
// testbench for the interrupt flag/enable register block
`timescale 1ns/1ps
module tb;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, global_irq_en, pready, pslverr;
  logic        irq_request, wake_up, er;
  logic [11:0] paddr, fire;
  logic [31:0] pwdata, prdata, q, prdata_s, qs;
  logic [3:0]  pstrb;
  pifr_pkg::pifr_events_t events, irq_pending;
  int          errors, tests_run, wakes, seed, k, e, r;
  int          enb_t[12] = '{0, 1, 2, 3,
                             0, 1, 2, 3,
                             0, 1, 1, 0};
  logic [7:0]  msk_t[4] = '{8'h33, 8'hFF, 8'hFF, 8'h33};
  logic [7:0]  msk_s[4] = '{8'h11, 8'h33, 8'h33, 8'h33};
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (wake_up === 1'b1) wakes++;
  pifr_irq_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .events, .global_irq_en, .irq_pending, .irq_request,
    .wake_up);
  pifr_evt_src src (.fire, .pclk, .presetn, .events);
  // smallest configuration on the same bus, read back alongside
  pifr_irq_regs #(
    .HAS_ASYNC_PORT    (1'b0),
    .HAS_STANDARD_TMR  (1'b0),
    .HAS_DUAL_PERIODIC (1'b0)
  ) uut_small (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata(prdata_s), .pready(), .pslverr(), .events, .global_irq_en, .irq_pending(),
    .irq_request(), .wake_up());
  // status word: one pending bit per enable position, request level at bit 16
  function automatic logic [31:0] exp_status(input int r, input int e, input int g);
    return (32'h0000_0001 << (r * 4 + e)) | (32'(g) << 16);
  endfunction
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      errors++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [7:0] d, input logic [11:0] f);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h00_0000, d};
    fire <= f;
    @(posedge pclk);
    penable <= 1'b1;
    fire <= '0;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    qs = prdata_s;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pulse(input int i);
    @(posedge pclk);
    fire <= 12'(1 << i);
    @(posedge pclk);
    fire <= '0;
    repeat (3) @(posedge pclk);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    seed = 17761;
    {presetn, psel, penable, pwrite, global_irq_en} = '0;
    {paddr, fire, pwdata} = '0;
    pstrb = 4'hF;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (r = 0; r < 4; r++) begin
      apb(12'(r * 4), 1'b0, 8'h00, '0);
      chk("reset", 0, q);
      chk("reset_small", 0, qs);
      apb(12'(r * 4), 1'b1, 8'hFF, '0);
      apb(12'(r * 4), 1'b0, 8'h00, '0);
      chk("mask", 32'(msk_t[r]), q);
      chk("mask_small", 32'(msk_s[r]), qs);
    end
    for (k = 0; k < 24; k++) begin
      r = $random(seed) & 3;
      e = $random(seed) & 255;
      apb(12'(r * 4), 1'b1, 8'(e), '0);
      apb(12'(r * 4), 1'b0, 8'h00, '0);
      chk("rand", 32'(e & msk_t[r]), q);
      chk("rand_small", 32'(e & msk_s[r]), qs);
    end
    for (r = 0; r < 4; r++) apb(12'(r * 4), 1'b1, 8'h00, '0);
    pstrb <= 4'h0;
    apb(12'h000, 1'b1, 8'h11, '0);
    pstrb <= 4'hF;
    apb(12'h020, 1'b1, 8'hFF, '0);
    chk("err", 1, 32'(er));
    apb(12'h020, 1'b0, 8'h00, '0);
    chk("unmapped", 0, q);
    apb(12'h000, 1'b0, 8'h00, '0);
    chk("strobe", 0, q);
    wakes = 0;
    for (k = 0; k < 12; k++) begin
      r = k > 9 ? 0 : k > 5 ? 1 : k > 1 ? 2 : 3;
      e = enb_t[k];
      global_irq_en <= 1'(k % 2);
      apb(12'(r * 4), 1'b1, 8'(1 << e), '0);
      pulse(k);
      apb(12'(r * 4), 1'b0, 8'h00, '0);
      chk("flag", (1 << e) | (16 << e), q);
      chk("pending", 32'(1 << k), 32'(irq_pending));
      chk("request", 32'(k % 2), 32'(irq_request));
      apb(12'h010, 1'b0, 8'h00, '0);
      chk("status", exp_status(r, e, k % 2), q);
      apb(12'(r * 4), 1'b1, 8'(16 << e), '0);
      // the enable write lands at the edge the task returns on
      @(posedge pclk);
      chk("masked", 0, 32'(irq_pending));
    end
    chk("wakes", 12, wakes);
    apb(12'h000, 1'b1, 8'h00, '0);
    apb(12'h000, 1'b1, 8'h10, '0);
    pulse(11);
    chk("preset", 13, wakes);
    apb(12'h000, 1'b1, 8'h00, 12'h800);
    apb(12'h000, 1'b0, 8'h00, '0);
    chk("collide", 32'h0000_0010, q);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h000, 1'b0, 8'h00, '0);
    chk("rereset", 0, q);
    chk("rereset_small", 0, qs);
    close_out;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    close_out;
  end
endmodule // tb
